// *** rtl/image_block_transfer_queue.sv ***
/*
  Transfer controller: finished image blocks enter a four-entry first-in-first-out
  queue of block tags and are handed one at a time to the stream link.
  Assumes the block source, the link and STREAM_CLOSE_I run on REF_CLK_I, and that
  the link reports the end of each block it was given with TX_DONE_I.
*/
// The address map and register access over Avalon-MM were chosen for this implementation.
module image_block_transfer_queue (
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  input wire logic [xfer_pkg::ADDR_W-1:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  output logic [31:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  input wire logic BLK_VALID_I,
  input wire logic [xfer_pkg::TAG_W-1:0] BLK_TAG_I,
  output logic TX_START_O,
  output logic [xfer_pkg::TAG_W-1:0] TX_TAG_O,
  output logic TX_BUSY_O,
  input wire logic TX_DONE_I,
  input wire logic STREAM_CLOSE_I
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  xfer_pkg::cfg_t cfg_q;
  xfer_pkg::tx_state_t state_q;
  logic ack_q;
  logic [31:0] rdata_q;
  logic [xfer_pkg::TAG_W-1:0] mem_q [xfer_pkg::QUEUE_DEPTH];
  logic [xfer_pkg::PTR_W-1:0] head_q;
  logic [xfer_pkg::PTR_W-1:0] tail;
  logic [xfer_pkg::OCC_W-1:0] occ_q;
  logic [31:0] lost_q;
  logic run_q;
  logic [xfer_pkg::TOTAL_W-1:0] remain_q;
  logic [xfer_pkg::TAG_W-1:0] tag_q;
  logic start_q;
  logic [xfer_pkg::TAG_W-1:0] head_tag;
  logic wr_commit;
  logic cmd_wr;
  logic go_cmd;
  logic halt_cmd;
  logic user_mode;
  logic multi_op;
  logic full;
  logic push;
  logic pop;
  logic send_ok;
  logic done;

  function automatic logic hit(input logic [xfer_pkg::ADDR_W-1:0] a,
                               input logic [xfer_pkg::ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Avalon slave: one wait cycle, so data settles in a flop before release

  assign AVS_WAITREQUEST_O = (AVS_READ_I | AVS_WRITE_I) & ~ack_q;
  assign AVS_READDATA_O = rdata_q;
  assign wr_commit = AVS_WRITE_I & ack_q;
  assign cmd_wr = wr_commit & hit(AVS_ADDRESS_I, xfer_pkg::OFS_CMD);
  assign user_mode = (cfg_q.method == xfer_pkg::METHOD_USER);
  assign multi_op = (cfg_q.op == xfer_pkg::OP_MULTI);
  // Commands outside user mode are dropped
  assign go_cmd = cmd_wr & user_mode & AVS_WRITEDATA_I[xfer_pkg::CMD_GO_BIT];
  assign halt_cmd = cmd_wr & user_mode & AVS_WRITEDATA_I[xfer_pkg::CMD_HALT_BIT];

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (AVS_READ_I | AVS_WRITE_I) & ~ack_q;
    end
  end

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      rdata_q <= 32'h0000_0000;
    end else if (AVS_READ_I & ~ack_q) begin
      case (AVS_ADDRESS_I)
        xfer_pkg::OFS_METHOD: rdata_q <= {30'h0, cfg_q.method};
        xfer_pkg::OFS_OP: rdata_q <= {31'h0, cfg_q.op};
        xfer_pkg::OFS_TOTAL: rdata_q <= {16'h0, cfg_q.total};
        xfer_pkg::OFS_CAPACITY: rdata_q <= {29'h0, xfer_pkg::QUEUE_DEPTH};
        xfer_pkg::OFS_OCCUPANCY: rdata_q <= {29'h0, occ_q};
        xfer_pkg::OFS_LOST: rdata_q <= lost_q;
        xfer_pkg::OFS_POLICY: rdata_q <= {31'h0, xfer_pkg::POLICY_FIFO};
        xfer_pkg::OFS_STATUS: rdata_q <= {remain_q, 14'h0, run_q, TX_BUSY_O};
        default: rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // Illegal method codes are not stored; the policy word accepts only FIFO
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      cfg_q <= xfer_pkg::CFG_RESET;
    end else if (wr_commit) begin
      if (hit(AVS_ADDRESS_I, xfer_pkg::OFS_METHOD) && AVS_WRITEDATA_I[1:0] != 2'h3) begin
        cfg_q.method <= xfer_pkg::method_t'(AVS_WRITEDATA_I[1:0]);
      end
      if (hit(AVS_ADDRESS_I, xfer_pkg::OFS_OP)) begin
        cfg_q.op <= xfer_pkg::op_t'(AVS_WRITEDATA_I[0]);
      end
      if (hit(AVS_ADDRESS_I, xfer_pkg::OFS_TOTAL)) begin
        cfg_q.total <= AVS_WRITEDATA_I[xfer_pkg::TOTAL_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Queue of block tags

  assign push = BLK_VALID_I;
  assign full = (occ_q == xfer_pkg::QUEUE_DEPTH);
  assign tail = head_q + occ_q[xfer_pkg::PTR_W-1:0];
  assign head_tag = mem_q[head_q];
  assign done = (state_q == xfer_pkg::TX_BUSY) & TX_DONE_I;
  assign send_ok = ~user_mode | run_q;
  // Idle, data waiting and allowed: dispatch at once
  assign pop = (state_q == xfer_pkg::TX_IDLE) & (occ_q != 3'h0) & send_ok
             & ~STREAM_CLOSE_I;

  for (genvar i = 0; i < 4; i++) begin : g_entry
    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
      if (RST_I) begin
        mem_q[i] <= 16'h0000;
      end else if (push && !STREAM_CLOSE_I && tail == xfer_pkg::PTR_W'(i)) begin
        mem_q[i] <= BLK_TAG_I;
      end
    end
  end

  // Only a channel close empties the queue; nothing tied to acquisition touches it
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      head_q <= 2'h0;
      occ_q <= 3'h0;
    end else if (STREAM_CLOSE_I) begin
      head_q <= 2'h0;
      occ_q <= 3'h0;
    end else if (push && pop) begin
      head_q <= head_q + 2'h1;
    end else if (push && full) begin
      head_q <= head_q + 2'h1;
    end else if (push) begin
      occ_q <= occ_q + 3'h1;
    end else if (pop) begin
      head_q <= head_q + 2'h1;
      occ_q <= occ_q - 3'h1;
    end
  end

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      lost_q <= 32'h0000_0000;
    end else if (push && full && !pop && !STREAM_CLOSE_I) begin
      lost_q <= lost_q + 32'h0000_0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit state: the block in flight lives outside the queue, so an
  // overwrite can never reach it

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      state_q <= xfer_pkg::TX_IDLE;
      tag_q <= 16'h0000;
      start_q <= 1'b0;
    end else begin
      start_q <= pop;
      case (state_q)
        xfer_pkg::TX_IDLE: begin
          if (pop) begin
            state_q <= xfer_pkg::TX_BUSY;
            tag_q <= head_tag;
          end
        end
        xfer_pkg::TX_BUSY: begin
          if (STREAM_CLOSE_I || TX_DONE_I) begin
            state_q <= xfer_pkg::TX_IDLE;
          end
        end
        default: state_q <= xfer_pkg::TX_IDLE;
      endcase
    end
  end

  assign TX_START_O = start_q;
  assign TX_TAG_O = tag_q;
  assign TX_BUSY_O = (state_q == xfer_pkg::TX_BUSY);

  ////////////////////////////////////////////////////////////////////////////
  // User controlled run gate; halt only blocks new dispatches

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      run_q <= 1'b0;
      remain_q <= 16'h0000;
    end else if (STREAM_CLOSE_I || !user_mode || halt_cmd) begin
      run_q <= 1'b0;
    end else if (go_cmd && multi_op) begin
      remain_q <= cfg_q.total;
      run_q <= (cfg_q.total != 16'h0000);
    end else if (go_cmd) begin
      run_q <= 1'b1;
    end else if (done && run_q && multi_op) begin
      remain_q <= remain_q - 16'h0001;
      if (remain_q == 16'h0001) begin
        run_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);

  sequence s_go_multi;
    go_cmd && !halt_cmd && multi_op && cfg_q.total != 16'h0000 && !STREAM_CLOSE_I;
  endsequence

  sequence s_last_done;
    done && run_q && multi_op && user_mode && remain_q == 16'h0001 && !STREAM_CLOSE_I
      && !halt_cmd && !go_cmd;
  endsequence

  property p_occ_bound;
    occ_q <= xfer_pkg::QUEUE_DEPTH;
  endproperty
  a_occ_bound: assert property (p_occ_bound) else $error("occupancy above capacity");

  property p_fifo_order;
    pop |=> TX_START_O && TX_BUSY_O && TX_TAG_O == $past(head_tag);
  endproperty
  a_fifo_order: assert property (p_fifo_order) else $error("sent block is not oldest");

  property p_overflow;
    push && full && !pop && !STREAM_CLOSE_I |=> lost_q == $past(lost_q) + 32'h1 && occ_q == 3'h4;
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow not counted");

  property p_no_loss;
    !(push && full && !pop) |=> $stable(lost_q);
  endproperty
  a_no_loss: assert property (p_no_loss) else $error("lost count moved without overflow");

  property p_inflight_kept;
    TX_BUSY_O && !TX_DONE_I && !STREAM_CLOSE_I |=> TX_BUSY_O && $stable(TX_TAG_O) && !TX_START_O;
  endproperty
  a_inflight_kept: assert property (p_inflight_kept) else $error("block in flight disturbed");

  property p_auto_dispatch;
    !user_mode && !TX_BUSY_O && occ_q != 3'h0 && !STREAM_CLOSE_I |=> TX_START_O;
  endproperty
  a_auto_dispatch: assert property (p_auto_dispatch) else $error("waiting block not sent");

  property p_close_flush;
    STREAM_CLOSE_I |=> occ_q == 3'h0 && !TX_BUSY_O && !run_q;
  endproperty
  a_close_flush: assert property (p_close_flush) else $error("close left queue state");

  property p_halted;
    user_mode && !run_q |-> !pop;
  endproperty
  a_halted: assert property (p_halted) else $error("dispatch while halted");

  property p_halt_finish;
    halt_cmd && TX_BUSY_O && !TX_DONE_I && !STREAM_CLOSE_I |=> TX_BUSY_O && !run_q;
  endproperty
  a_halt_finish: assert property (p_halt_finish) else $error("halt cut block short");

  property p_multi_load;
    s_go_multi |=> run_q && remain_q == $past(cfg_q.total);
  endproperty
  a_multi_load: assert property (p_multi_load) else $error("remaining count not loaded");

  property p_multi_end;
    s_last_done |=> !run_q ##1 !TX_START_O;
  endproperty
  a_multi_end: assert property (p_multi_end) else $error("multi-block did not stop");

  property p_cmd_user_only;
    cmd_wr && !user_mode |=> !run_q;
  endproperty
  a_cmd_user_only: assert property (p_cmd_user_only) else $error("command taken outside user");

  // A finished block with more waiting is followed by the next after one idle
  // cycle; a longer gap would stall a fast link for no reason
  sequence s_block_end;
    done && occ_q != 3'h0 && !user_mode && !STREAM_CLOSE_I;
  endsequence

  sequence s_idle_gap;
    !STREAM_CLOSE_I && !user_mode;
  endsequence

  property p_next_block;
    s_block_end ##1 s_idle_gap |=> TX_START_O && TX_BUSY_O;
  endproperty
  a_next_block: assert property (p_next_block) else $error("next block not sent");

  property p_hold_waiting;
    push && !pop && !full && !STREAM_CLOSE_I |=> occ_q == $past(occ_q) + 3'h1;
  endproperty
  a_hold_waiting: assert property (p_hold_waiting) else $error("waiting block not held");

  property p_total_unused;
    go_cmd && !multi_op && !halt_cmd && !STREAM_CLOSE_I |=> run_q && $stable(remain_q);
  endproperty
  a_total_unused: assert property (p_total_unused) else $error("total not ignored");

  property p_multi_count;
    done && run_q && multi_op && user_mode && !STREAM_CLOSE_I && !halt_cmd && !go_cmd
      |=> remain_q == $past(remain_q) - 16'h0001;
  endproperty
  a_multi_count: assert property (p_multi_count) else $error("remain not decremented");

endmodule

// *** rtl/xfer_pkg.sv ***
/*
  Constants, types and register map of the image block transfer queue.
  Assumes a single 200 MHz clock domain and a 32-bit Avalon-MM register bus.
*/
package xfer_pkg;

  localparam int TAG_W = 16;
  localparam int PTR_W = 2;
  localparam int OCC_W = 3;
  localparam int TOTAL_W = 16;
  localparam int ADDR_W = 6;

  localparam logic [OCC_W-1:0] QUEUE_DEPTH = 3'h4;

  // Byte addresses of the register words
  localparam logic [ADDR_W-1:0] OFS_METHOD = 6'h00;
  localparam logic [ADDR_W-1:0] OFS_OP = 6'h04;
  localparam logic [ADDR_W-1:0] OFS_TOTAL = 6'h08;
  localparam logic [ADDR_W-1:0] OFS_CAPACITY = 6'h0c;
  localparam logic [ADDR_W-1:0] OFS_OCCUPANCY = 6'h10;
  localparam logic [ADDR_W-1:0] OFS_LOST = 6'h14;
  localparam logic [ADDR_W-1:0] OFS_POLICY = 6'h18;
  localparam logic [ADDR_W-1:0] OFS_CMD = 6'h1c;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 6'h20;

  // Command word bits
  localparam int CMD_GO_BIT = 0;
  localparam int CMD_HALT_BIT = 1;

  // Status word bits
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_RUN_BIT = 1;
  localparam int STAT_REMAIN_LSB = 16;

  typedef enum logic [1:0] {
    METHOD_BASIC = 2'h0,
    METHOD_AUTO = 2'h1,
    METHOD_USER = 2'h2
  } method_t;

  typedef enum logic [0:0] {
    OP_CONTINUOUS = 1'h0,
    OP_MULTI = 1'h1
  } op_t;

  typedef enum logic [0:0] {
    POLICY_FIFO = 1'h0
  } policy_t;

  typedef enum logic [0:0] {
    TX_IDLE = 1'h0,
    TX_BUSY = 1'h1
  } tx_state_t;

  typedef struct packed {
    method_t method;
    op_t op;
    logic [TOTAL_W-1:0] total;
  } cfg_t;

  localparam cfg_t CFG_RESET = '{method: METHOD_BASIC, op: OP_CONTINUOUS, total: 16'h0001};

endpackage

// *** testbench/link_model.sv ***
/*
  Behavioural stream link that takes one block at a time from the queue.
  Assumes start, busy and done all live on the queue's clock.
*/
module link_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic busy_i,
  input wire logic [7:0] lat_i,
  output logic done_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] left_q;
  // A block aborted by a close is forgotten, so no stray done follows it
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      left_q <= 8'h00;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (start_i) begin
        left_q <= lat_i;
      end else if (!busy_i) begin
        left_q <= 8'h00;
      end else if (left_q == 8'h01) begin
        left_q <= 8'h00;
        done_o <= 1'b1;
      end else if (left_q != 8'h00) begin
        left_q <= left_q - 8'h01;
      end
    end
  end
endmodule

// *** testbench/tb_top.sv ***
/*
  Self-checking bench for the block transfer queue.
  Assumes the link model answers each start with one done after lat cycles.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, rd, wr, blk_valid, close, start, busy, done, waitreq;
  logic [5:0] addr;
  logic [31:0] wdata, rdata, v;
  logic [15:0] blk_tag, tx_tag;
  logic [7:0] lat;
  logic [15:0] sent[$];
  int err_count, total_checks;

  image_block_transfer_queue DUT (
    .REF_CLK_I(clk), .RST_I(rst), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd),
    .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata), .AVS_READDATA_O(rdata),
    .AVS_WAITREQUEST_O(waitreq), .BLK_VALID_I(blk_valid), .BLK_TAG_I(blk_tag),
    .TX_START_O(start), .TX_TAG_O(tx_tag), .TX_BUSY_O(busy), .TX_DONE_I(done),
    .STREAM_CLOSE_I(close)
  );
  link_model link (.clk_i(clk), .rst_i(rst), .start_i(start), .busy_i(busy),
    .lat_i(lat), .done_o(done));

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) if (start === 1'b1) sent.push_back(tx_tag);

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (waitreq !== 1'b0 && n < 100);
    if (waitreq !== 1'b0) err_count++;
    v = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic rchk(input logic [5:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(v, exp);
  endtask

  task automatic push(input logic [15:0] t);
    @(posedge clk);
    blk_valid <= 1'b1;
    blk_tag <= t;
    @(posedge clk);
    blk_valid <= 1'b0;
  endtask

  // Quiet means four idle samples in a row, longer than the gap between blocks
  task automatic quiet();
    int q = 0;
    int n = 0;
    while (q < 4 && n < 3000) begin
      @(posedge clk);
      n++;
      q = busy ? 0 : q + 1;
    end
    if (q < 4) err_count++;
  endtask

  task automatic stop_test();
    if (err_count == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    stop_test();
  end

  initial begin
    rst = 1'b1;
    {rd, wr, blk_valid, close} = 4'h0;
    addr = 6'h00;
    wdata = 32'h0;
    blk_tag = 16'h0;
    lat = 8'h02;
    err_count = 0;
    total_checks = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    bus(1'b1, xfer_pkg::OFS_CAPACITY, 32'hf);
    bus(1'b1, xfer_pkg::OFS_POLICY, 32'h1);
    bus(1'b1, 6'h24, 32'h5);
    for (int i = 0; i < 10; i++) rchk(6'(i * 4), (i == 2) ? 1 : (i == 3) ? 4 : 0);
    bus(1'b1, xfer_pkg::OFS_METHOD, 32'h3);
    rchk(xfer_pkg::OFS_METHOD, 32'h0);
    bus(1'b1, xfer_pkg::OFS_METHOD, 32'h1);
    rchk(xfer_pkg::OFS_METHOD, 32'h1);
    // Halt outside user mode must not stop automatic streaming
    bus(1'b1, xfer_pkg::OFS_CMD, 32'h2);
    sent.delete();
    for (int i = 1; i < 4; i++) push(16'h0a00 + 16'(i));
    quiet();
    chk(sent.size(), 3);
    for (int i = 0; i < 3; i++) chk(sent[i], 16'h0a01 + 16'(i));
    bus(1'b1, xfer_pkg::OFS_METHOD, 32'h0);
    lat <= 8'h28;
    sent.delete();
    push(16'h0b00);
    repeat (3) @(posedge clk);
    for (int i = 1; i < 6; i++) push(16'h0b00 + 16'(i));
    rchk(xfer_pkg::OFS_OCCUPANCY, 32'h4);
    rchk(xfer_pkg::OFS_LOST, 32'h1);
    lat <= 8'h02;
    quiet();
    chk(sent.size(), 5);
    chk(sent[0], 16'h0b00);
    for (int i = 1; i < 5; i++) chk(sent[i], 16'h0b01 + 16'(i));
    bus(1'b1, xfer_pkg::OFS_METHOD, 32'h2);
    sent.delete();
    push(16'h0c01);
    quiet();
    chk(sent.size(), 0);
    lat <= 8'h28;
    bus(1'b1, xfer_pkg::OFS_CMD, 32'h1);
    push(16'h0c02);
    bus(1'b1, xfer_pkg::OFS_CMD, 32'h2);
    quiet();
    chk(sent.size(), 1);
    rchk(xfer_pkg::OFS_OCCUPANCY, 32'h1);
    rchk(xfer_pkg::OFS_CMD, 32'h0);
    lat <= 8'h02;
    bus(1'b1, xfer_pkg::OFS_OP, 32'h1);
    bus(1'b1, xfer_pkg::OFS_TOTAL, 32'h2);
    push(16'h0c03);
    push(16'h0c04);
    sent.delete();
    bus(1'b1, xfer_pkg::OFS_CMD, 32'h1);
    quiet();
    chk(sent.size(), 2);
    chk({sent[0], sent[1]}, 32'h0c020c03);
    rchk(xfer_pkg::OFS_STATUS, 32'h0);
    bus(1'b1, xfer_pkg::OFS_OP, 32'h0);
    sent.delete();
    bus(1'b1, xfer_pkg::OFS_CMD, 32'h1);
    push(16'h0c05);
    push(16'h0c06);
    quiet();
    chk(sent.size(), 3);
    bus(1'b1, xfer_pkg::OFS_METHOD, 32'h0);
    lat <= 8'h28;
    sent.delete();
    for (int i = 1; i < 4; i++) push(16'h0d00 + 16'(i));
    @(posedge clk);
    close <= 1'b1;
    @(posedge clk);
    close <= 1'b0;
    rchk(xfer_pkg::OFS_OCCUPANCY, 32'h0);
    chk(busy, 1'b0);
    quiet();
    chk(sent.size(), 1);
    rchk(xfer_pkg::OFS_LOST, 32'h1);
    stop_test();
  end
endmodule
